//--- design/rcc_defs.vh
`ifndef RCC_DEFS_VH
`define RCC_DEFS_VH
// configuration codes
`define RCC_CFG_EMPTY      8'h00
`define RCC_CFG_IN1B       8'h10
`define RCC_CFG_IN2B       8'h11
`define RCC_CFG_HEAD_MS    8'h15
`define RCC_CFG_OUT1B      8'h20
`define RCC_CFG_IO1B       8'h30
`define RCC_CFG_HEAD_SC    8'h31
`define RCC_CFG_IN1W       8'h50
`define RCC_CFG_IN2W       8'h51
`define RCC_CFG_IN3W       8'h52
`define RCC_CFG_IN4W       8'h53
`define RCC_CFG_IN5W       8'h54
`define RCC_CFG_IN7W       8'h56
`define RCC_CFG_IN9W       8'h58
`define RCC_CFG_OUT1W      8'h60
`define RCC_CFG_SPECIAL    8'hc0
`define RCC_CFG_AO_B1      8'h43
`define RCC_CFG_AO_B2      8'h40
`define RCC_CFG_HEAD_B1    8'h01
`define RCC_CFG_HEAD_B2    8'h07
// head data modes
`define RCC_HEAD_NONE      2'h0
`define RCC_HEAD_SC        2'h1
`define RCC_HEAD_MS        2'h2
`define RCC_HEAD_BOTH      2'h3
// module kinds
`define RCC_KIND_EMPTY     4'h0
`define RCC_KIND_IN1B      4'h1
`define RCC_KIND_IN2B      4'h2
`define RCC_KIND_OUT1B     4'h3
`define RCC_KIND_IO1B      4'h4
`define RCC_KIND_IN1W      4'h5
`define RCC_KIND_IN2W      4'h6
`define RCC_KIND_IN3W      4'h7
`define RCC_KIND_IN4W      4'h8
`define RCC_KIND_IN5W      4'h9
`define RCC_KIND_IN7W      4'ha
`define RCC_KIND_IN9W      4'hb
`define RCC_KIND_OUT1W     4'hc
`define RCC_KIND_AO4W      4'hd
`define RCC_KIND_DOSTAT    4'he
// command codes
`define RCC_PARAM_ALL      8'h00
`define RCC_CMD_CLR_CNT    8'h08
`define RCC_CMD_COLD       8'hf8
`define RCC_CMD_WARM       8'hf9
`define RCC_CMD_PASSIVE    8'hf5
`define RCC_CMD_ACTIVE     8'hf6
`define RCC_CMD_SWAP       8'hf7
// field positions in the order word
`define RCC_ORD_PARAM_HI   15
`define RCC_ORD_PARAM_LO   8
`define RCC_ORD_CMD_HI     7
`define RCC_ORD_CMD_LO     0
// reset values
`define RCC_ORDER_RST      16'h0000
`endif

//--- design/rcc_unit.v
`timescale 1ns/1ps
`include "rcc_defs.vh"

module rcc_unit #(
   parameter NUM_SLOTS = 46,
   parameter STAT_BITS = 48
) (
   input  wire                     I_CLOCK,
   input  wire                     I_RST,
   input  wire                     I_CE,
   input  wire [1:0]               I_HEAD_MODE,
   input  wire [4*NUM_SLOTS-1:0]   I_SLOT_KIND,
   input  wire [NUM_SLOTS-1:0]     I_SLOT_ACTIVE,
   input  wire [NUM_SLOTS-1:0]     I_SLOT_FAULT,
   input  wire [15:0]              I_GLOBAL_STATUS,
   input  wire                     I_REQ_VALID,
   input  wire [15:0]              I_REQ_ORDER,
   input  wire                     I_HEAD_ACTIVE_IN,
   output reg  [8*(3+3*NUM_SLOTS)-1:0] O_CFG_STRING,
   output reg  [7:0]               O_CFG_LEN,
   output reg  [7:0]               O_HEAD_IN_BYTES,
   output reg  [7:0]               O_HEAD_OUT_BYTES,
   output reg  [63:0]              O_RESP_HEAD,
   output reg                      O_RESP_VALID,
   output reg                      O_CLR_ALL_CNT,
   output reg                      O_CLR_SLOT_CNT,
   output reg  [7:0]               O_CLR_SLOT,
   output reg                      O_COLD_START,
   output reg                      O_WARM_RESTART,
   output reg                      O_HEAD_ACTIVE,
   output reg                      O_PARTNER_TAKEOVER,
   output reg                      O_PARTNER_RELEASE
);

   localparam CFG_W = 8*(3+3*NUM_SLOTS);

   reg  [15:0]     prev_order_reg;
   wire [7:0]      ord_param;
   wire [7:0]      ord_cmd;
   wire            order_new;
   wire            par_zero;

   // order word split into parameter and command bytes
   assign ord_param = I_REQ_ORDER[`RCC_ORD_PARAM_HI:`RCC_ORD_PARAM_LO];
   assign ord_cmd   = I_REQ_ORDER[`RCC_ORD_CMD_HI:`RCC_ORD_CMD_LO];
   assign order_new = I_REQ_VALID && (I_REQ_ORDER != prev_order_reg);
   assign par_zero  = (ord_param == `RCC_PARAM_ALL);

   // code bytes and code length per slot
   wire [23:0]     slot_code [0:NUM_SLOTS-1];
   wire [1:0]      slot_clen [0:NUM_SLOTS-1];
   wire [NUM_SLOTS-1:0] stat_bit;

   genvar g;
   generate
      for (g = 0; g < NUM_SLOTS; g = g + 1) begin : g_slot
         wire [3:0] kind = I_SLOT_KIND[4*g+3:4*g];
         reg  [23:0] code;
         reg  [1:0]  clen;
         always @* begin
            clen = 2'd1;
            code = 24'h000000;
            case (kind)
               `RCC_KIND_IN1B: begin
                  code = {16'h0000, `RCC_CFG_IN1B};
                  clen = 2'd1;
               end
               `RCC_KIND_IN2B: begin
                  code = {16'h0000, `RCC_CFG_IN2B};
                  clen = 2'd1;
               end
               `RCC_KIND_OUT1B: begin
                  code = {16'h0000, `RCC_CFG_OUT1B};
                  clen = 2'd1;
               end
               `RCC_KIND_IO1B: begin
                  code = {16'h0000, `RCC_CFG_IO1B};
                  clen = 2'd1;
               end
               `RCC_KIND_IN1W: begin
                  code = {16'h0000, `RCC_CFG_IN1W};
                  clen = 2'd1;
               end
               `RCC_KIND_IN2W: begin
                  code = {16'h0000, `RCC_CFG_IN2W};
                  clen = 2'd1;
               end
               `RCC_KIND_IN3W: begin
                  code = {16'h0000, `RCC_CFG_IN3W};
                  clen = 2'd1;
               end
               `RCC_KIND_IN4W: begin
                  code = {16'h0000, `RCC_CFG_IN4W};
                  clen = 2'd1;
               end
               `RCC_KIND_IN5W: begin
                  code = {16'h0000, `RCC_CFG_IN5W};
                  clen = 2'd1;
               end
               `RCC_KIND_IN7W: begin
                  code = {16'h0000, `RCC_CFG_IN7W};
                  clen = 2'd1;
               end
               `RCC_KIND_IN9W: begin
                  code = {16'h0000, `RCC_CFG_IN9W};
                  clen = 2'd1;
               end
               `RCC_KIND_OUT1W: begin
                  code = {16'h0000, `RCC_CFG_OUT1W};
                  clen = 2'd1;
               end
               `RCC_KIND_DOSTAT: begin
                  code = {16'h0000, `RCC_CFG_HEAD_SC}; // output with status, two bytes each way
                  clen = 2'd1;
               end
               `RCC_KIND_AO4W: begin
                  code = {`RCC_CFG_SPECIAL, `RCC_CFG_AO_B1, `RCC_CFG_AO_B2};
                  clen = 2'd3;
               end
               default: begin
                  code = {16'h0000, `RCC_CFG_EMPTY};
                  clen = 2'd1;
               end
            endcase
         end
         assign slot_code[g] = code;
         assign slot_clen[g] = clen;
         // module status: active and fault-free
         assign stat_bit[g] = I_SLOT_ACTIVE[g] & ~I_SLOT_FAULT[g];
      end
   endgenerate

   // head code first, then module codes in slot order, packed from the msb
   reg [CFG_W-1:0] cfg_next;
   reg [7:0]       len_next;
   reg [7:0]       hin_next;
   reg [7:0]       hout_next;
   integer         i;
   always @* begin
      cfg_next  = {CFG_W{1'b0}};
      hin_next  = 8'd0;
      hout_next = 8'd0;
      case (I_HEAD_MODE)  // one entry only; the redundant partner adds nothing
         // status/command register only
         `RCC_HEAD_SC: begin
            cfg_next[CFG_W-1 -: 8] = `RCC_CFG_HEAD_SC;
            len_next  = 8'd1;
            hin_next  = 8'd2;
            hout_next = 8'd2;
         end
         // module status only
         `RCC_HEAD_MS: begin
            cfg_next[CFG_W-1 -: 8] = `RCC_CFG_HEAD_MS;
            len_next  = 8'd1;
            hin_next  = 8'd6;
         end
         // status/command register and module status
         `RCC_HEAD_BOTH: begin
            cfg_next[CFG_W-1 -: 24] = {`RCC_CFG_SPECIAL, `RCC_CFG_HEAD_B1, `RCC_CFG_HEAD_B2};
            len_next  = 8'd3;
            hin_next  = 8'd8;
            hout_next = 8'd2;
         end
         // head without data
         default: begin
            cfg_next[CFG_W-1 -: 8] = `RCC_CFG_EMPTY;
            len_next  = 8'd1;
         end
      endcase
      // module codes after the head entry
      for (i = 0; i < NUM_SLOTS; i = i + 1) begin
         if (slot_clen[i] == 2'd3) begin
            cfg_next[CFG_W-1-8*len_next -: 24] = slot_code[i];
            len_next = len_next + 8'd3;
         end else begin
            cfg_next[CFG_W-1-8*len_next -: 8] = slot_code[i][7:0];
            len_next = len_next + 8'd1;
         end
      end
   end

   // registered configuration outputs
   always @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         O_CFG_STRING     <= {CFG_W{1'b0}};
         O_CFG_LEN        <= 8'd0;
         O_HEAD_IN_BYTES  <= 8'd0;
         O_HEAD_OUT_BYTES <= 8'd0;
      end else if (I_CE) begin
         O_CFG_STRING     <= cfg_next;
         O_CFG_LEN        <= len_next;
         O_HEAD_IN_BYTES  <= hin_next;
         O_HEAD_OUT_BYTES <= hout_next;
      end
   end

   // response head: global status, then module status bits, after the request
   wire [STAT_BITS-1:0] stat_vec;

   // module status padded to the full field; 46 slots get two zero bits, 48 or more slots get none
   generate
      if (STAT_BITS > NUM_SLOTS) begin : g_pad
         assign stat_vec = {{(STAT_BITS-NUM_SLOTS){1'b0}}, stat_bit};
      end else begin : g_nopad
         assign stat_vec = stat_bit[STAT_BITS-1:0];
      end
   endgenerate
   always @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         O_RESP_HEAD  <= 64'h0;
         O_RESP_VALID <= 1'b0;
      end else if (I_CE) begin
         O_RESP_VALID <= I_REQ_VALID; // answer follows each request
         if (I_REQ_VALID) begin
            O_RESP_HEAD <= {I_GLOBAL_STATUS, stat_vec};
         end
      end
   end

   // order word decode; one-cycle command pulses
   always @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         prev_order_reg     <= `RCC_ORDER_RST;
         O_CLR_ALL_CNT      <= 1'b0;
         O_CLR_SLOT_CNT     <= 1'b0;
         O_CLR_SLOT         <= 8'h00;
         O_COLD_START       <= 1'b0;
         O_WARM_RESTART     <= 1'b0;
         O_HEAD_ACTIVE      <= 1'b0;
         O_PARTNER_TAKEOVER <= 1'b0;
         O_PARTNER_RELEASE  <= 1'b0;
      end else if (I_CE) begin
         O_CLR_ALL_CNT      <= 1'b0;
         O_CLR_SLOT_CNT     <= 1'b0;
         O_COLD_START       <= 1'b0;
         O_WARM_RESTART     <= 1'b0;
         O_PARTNER_TAKEOVER <= 1'b0;
         O_PARTNER_RELEASE  <= 1'b0;
         O_HEAD_ACTIVE      <= I_HEAD_ACTIVE_IN;
         if (order_new) begin
            prev_order_reg <= I_REQ_ORDER;
            case (ord_cmd)
               // counter clear, all slots or the one named
               `RCC_CMD_CLR_CNT: begin
                  O_CLR_ALL_CNT  <= par_zero;
                  O_CLR_SLOT_CNT <= ~par_zero;
                  O_CLR_SLOT     <= ord_param;
               end
               // cold start, parameter must be zero
               `RCC_CMD_COLD: begin
                  O_COLD_START   <= par_zero;
               end
               // warm restart, parameter must be zero
               `RCC_CMD_WARM: begin
                  O_WARM_RESTART <= par_zero;
               end
               // go passive, only from the active role
               `RCC_CMD_PASSIVE: if (par_zero && I_HEAD_ACTIVE_IN) begin
                  O_HEAD_ACTIVE      <= 1'b0;
                  O_PARTNER_TAKEOVER <= 1'b1;
               end
               // go active, only from the passive role
               `RCC_CMD_ACTIVE: if (par_zero && !I_HEAD_ACTIVE_IN) begin
                  O_HEAD_ACTIVE     <= 1'b1;
                  O_PARTNER_RELEASE <= 1'b1;
               end
               // role swap from either role
               `RCC_CMD_SWAP: if (par_zero) begin
                  O_HEAD_ACTIVE      <= ~I_HEAD_ACTIVE_IN;
                  O_PARTNER_TAKEOVER <= I_HEAD_ACTIVE_IN;
                  O_PARTNER_RELEASE  <= ~I_HEAD_ACTIVE_IN;
               end
               // anything else leaves every output alone
               default: ; // unknown commands do nothing
            endcase
         end
      end
   end

endmodule // rcc_unit

//--- dv/rcc_unit_properties.sv
`timescale 1ns/1ps
module rcc_unit_chk #(
   parameter NUM_SLOTS = 46
) (
   input wire                 I_CLOCK,
   input wire                 I_RST,
   input wire                 I_CE,
   input wire                 I_REQ_VALID,
   input wire [15:0]          I_REQ_ORDER,
   input wire [15:0]          I_GLOBAL_STATUS,
   input wire [NUM_SLOTS-1:0] I_SLOT_ACTIVE,
   input wire [NUM_SLOTS-1:0] I_SLOT_FAULT,
   input wire                 I_HEAD_ACTIVE_IN,
   input wire [63:0]          O_RESP_HEAD,
   input wire                 O_RESP_VALID,
   input wire                 O_CLR_ALL_CNT,
   input wire                 O_CLR_SLOT_CNT,
   input wire [7:0]           O_CLR_SLOT,
   input wire                 O_COLD_START,
   input wire                 O_WARM_RESTART,
   input wire                 O_HEAD_ACTIVE,
   input wire                 O_PARTNER_TAKEOVER,
   input wire                 O_PARTNER_RELEASE
);
   reg  [15:0] prev_reg;
   wire        take    = I_CE && I_REQ_VALID;
   wire        any_cmd = O_CLR_ALL_CNT | O_CLR_SLOT_CNT | O_COLD_START | O_WARM_RESTART | O_PARTNER_TAKEOVER
                         | O_PARTNER_RELEASE;
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (I_RST);
   // copy of the last order word taken, zero after reset
   always @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST)
         prev_reg <= 16'h0000;
      else if (take)
         prev_reg <= I_REQ_ORDER;
   end
   AST_RESP_NEXT: assert property (take |=> O_RESP_VALID && O_RESP_HEAD[63:48] == $past(I_GLOBAL_STATUS))
      else $error("response or global status wrong after request");
   AST_RESP_BITS: assert property (take |=> O_RESP_HEAD[NUM_SLOTS-1:0] == $past(I_SLOT_ACTIVE & ~I_SLOT_FAULT))
      else $error("module status bits wrong");
   AST_RESP_CAUSE: assert property (O_RESP_VALID |-> $past(take))
      else $error("response without request");
   AST_SAME_ORDER: assert property (take && I_REQ_ORDER == prev_reg |=> !any_cmd)
      else $error("unchanged order word executed");
   AST_CLR_ALL: assert property (O_CLR_ALL_CNT |-> $past(take) && $past(I_REQ_ORDER) == 16'h0008)
      else $error("clear all without its order");
   AST_CLR_SLOT: assert property (O_CLR_SLOT_CNT |-> $past(I_REQ_ORDER[7:0]) == 8'h08
      && O_CLR_SLOT == $past(I_REQ_ORDER[15:8]) && O_CLR_SLOT != 8'h00) else $error("slot clear wrong");
   AST_RESTART: assert property (O_COLD_START || O_WARM_RESTART
      |-> $past(I_REQ_ORDER) == (O_COLD_START ? 16'h00f8 : 16'h00f9)) else $error("restart without its order");
   AST_TAKEOVER: assert property (O_PARTNER_TAKEOVER |-> !O_HEAD_ACTIVE && $past(I_HEAD_ACTIVE_IN)
      && $past(I_REQ_ORDER) inside {16'h00f5, 16'h00f7}) else $error("takeover wrong");
   AST_RELEASE: assert property (O_PARTNER_RELEASE |-> O_HEAD_ACTIVE && !$past(I_HEAD_ACTIVE_IN)
      && $past(I_REQ_ORDER) inside {16'h00f6, 16'h00f7}) else $error("release wrong");
endmodule // rcc_unit_chk
bind rcc_unit rcc_unit_chk #(.NUM_SLOTS(NUM_SLOTS)) u_chk (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_CE(I_CE),
   .I_REQ_VALID(I_REQ_VALID), .I_REQ_ORDER(I_REQ_ORDER), .I_GLOBAL_STATUS(I_GLOBAL_STATUS),
   .I_SLOT_ACTIVE(I_SLOT_ACTIVE), .I_SLOT_FAULT(I_SLOT_FAULT), .I_HEAD_ACTIVE_IN(I_HEAD_ACTIVE_IN),
   .O_RESP_HEAD(O_RESP_HEAD), .O_RESP_VALID(O_RESP_VALID), .O_CLR_ALL_CNT(O_CLR_ALL_CNT),
   .O_CLR_SLOT_CNT(O_CLR_SLOT_CNT), .O_CLR_SLOT(O_CLR_SLOT), .O_COLD_START(O_COLD_START),
   .O_WARM_RESTART(O_WARM_RESTART), .O_HEAD_ACTIVE(O_HEAD_ACTIVE), .O_PARTNER_TAKEOVER(O_PARTNER_TAKEOVER),
   .O_PARTNER_RELEASE(O_PARTNER_RELEASE));

//--- dv/rcc_master_model.sv
`timescale 1ns/1ps
module rcc_master_model (
   input  wire        i_clock,
   output reg         o_req_valid,
   output reg  [15:0] o_req_order,
   input  wire        i_resp_valid,
   input  wire [63:0] i_resp_head
);
   reg        got_reg;
   reg [63:0] resp_reg;
   initial begin
      o_req_valid = 1'b0;
      o_req_order = 16'h5a5a;
   end
   // one cyclic exchange: order word goes out first, the response comes back after
   task exchange(input [15:0] ord);
      begin
         @(posedge i_clock);
         o_req_valid <= 1'b1;
         o_req_order <= ord;
         @(posedge i_clock);
         o_req_valid <= 1'b0;
         o_req_order <= ~ord; // released word never shows a stale value
         @(negedge i_clock);
         got_reg = i_resp_valid;
         resp_reg = i_resp_head;
      end
   endtask
endmodule // rcc_master_model

//--- dv/rcc_unit_bench.sv
`timescale 1ns/1ps
module rcc_unit_bench;
   localparam [119:0] CODES = 120'h31c060585654535251503020111000;
   localparam [31:0]  HIN   = 32'h08060200;
   localparam [31:0]  HOUT  = 32'h02000200;
   localparam [379:0] CORNER = {20'h10000, 20'h10008, 20'h10008, 20'h10508, 20'h100f8, 20'h100f9, 20'h100f5,
      20'h00000, 20'h000f5, 20'h000f6, 20'h10100, 20'h100f6, 20'h100f7, 20'h000f7, 20'h000f2, 20'h000f7,
      20'h101f8, 20'h100aa, 20'h100ff};
   reg          clk, rst, head_act;
   reg  [1:0]   head_mode;
   reg  [15:0]  kinds, gs, prev, ord;
   reg  [3:0]   act, flt;
   reg  [31:0]  r;
   reg  [47:0]  mw;
   reg  [19:0]  ent;
   integer      failures, n_checks, i, k;
   wire         req_valid, resp_valid, clr_all, clr_one, cold, warm, head_out, takeover, release_p;
   wire [15:0]  req_order;
   wire [119:0] cfg;
   wire [7:0]   cfg_len, in_b, out_b, clr_slot;
   wire [63:0]  resp;
   rcc_unit #(.NUM_SLOTS(4)) DUT (.I_CLOCK(clk), .I_RST(rst), .I_CE(1'b1), .I_HEAD_MODE(head_mode),
      .I_SLOT_KIND(kinds), .I_SLOT_ACTIVE(act), .I_SLOT_FAULT(flt), .I_GLOBAL_STATUS(gs),
      .I_REQ_VALID(req_valid), .I_REQ_ORDER(req_order), .I_HEAD_ACTIVE_IN(head_act), .O_CFG_STRING(cfg),
      .O_CFG_LEN(cfg_len), .O_HEAD_IN_BYTES(in_b), .O_HEAD_OUT_BYTES(out_b), .O_RESP_HEAD(resp),
      .O_RESP_VALID(resp_valid), .O_CLR_ALL_CNT(clr_all), .O_CLR_SLOT_CNT(clr_one), .O_CLR_SLOT(clr_slot),
      .O_COLD_START(cold), .O_WARM_RESTART(warm), .O_HEAD_ACTIVE(head_out), .O_PARTNER_TAKEOVER(takeover),
      .O_PARTNER_RELEASE(release_p));
   rcc_master_model u_mst (.i_clock(clk), .o_req_valid(req_valid), .o_req_order(req_order),
      .i_resp_valid(resp_valid), .i_resp_head(resp));
   // expected pulses {clr all, clr slot, cold, warm, takeover, release}
   function [5:0] exp_cmd(input [15:0] p, input [15:0] o, input a);
      begin
         exp_cmd = 6'h00;
         if (o !== p && o[7:0] == 8'h08)
            exp_cmd = (o[15:8] == 8'h00) ? 6'h20 : 6'h10;
         else if (o !== p && o[15:8] == 8'h00) begin
            case (o[7:0])
               8'hf8: exp_cmd = 6'h08;
               8'hf9: exp_cmd = 6'h04;
               8'hf5: exp_cmd = a ? 6'h02 : 6'h00;
               8'hf6: exp_cmd = a ? 6'h00 : 6'h01;
               8'hf7: exp_cmd = a ? 6'h02 : 6'h01;
               default: exp_cmd = 6'h00;
            endcase
         end
      end
   endfunction
   task chk(input [63:0] what, input [119:0] exp, input [119:0] got);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("[FAIL] %0s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   // one exchange with fresh random status, then all answers compared
   task step(input [15:0] o, input a);
      reg [5:0] e;
      begin
         @(posedge clk);
         r = $urandom;
         head_act <= a;
         gs <= r[15:0];
         act <= r[19:16];
         flt <= r[23:20];
         e = exp_cmd(prev, o, a);
         prev = o;
         u_mst.exchange(o);
         chk("resp_vld", 1, u_mst.got_reg);
         chk("resp", {gs, 44'h0, act & ~flt}, u_mst.resp_reg);
         chk("pulses", e, {clr_all, clr_one, cold, warm, takeover, release_p});
         chk("role", e[1] ? 1'b0 : (e[0] ? 1'b1 : a), head_out);
         if (e[4])
            chk("slot", o[15:8], clr_slot);
      end
   endtask
   task finish_test;
      begin
         if (failures == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
         end else begin
            $display("SIMULATION FAILED");
         end
         $finish;
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      {rst, head_act, head_mode, kinds, gs, act, flt, prev} = {2'b11, 2'h3, 16'h02bd, 24'h0, 16'h0};
      failures = 0;
      n_checks = 0;
      r = $urandom(32'h987ded62);
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      // configuration string over every slot kind and head mode
      for (k = 0; k < 15; k = k + 1) begin
         @(posedge clk);
         head_mode <= k[1:0];
         kinds <= {12'h02b, k[3:0]};
         repeat (2) @(posedge clk);
         @(negedge clk);
         mw = (k == 13) ? 48'hc04340581100 : {CODES[8*k +: 8], 40'h5811000000};
         chk("cfg", (k % 4 == 3) ? {24'hc00107, mw, 48'h0} : {(k % 4 == 1) ? 8'h31 : ((k % 4 == 2) ? 8'h15 : 8'h00),
            mw, 64'h0}, cfg);
         chk("cfg_len", (k % 4 == 3 ? 3 : 1) + (k == 13 ? 6 : 4), cfg_len);
         chk("hd_in", HIN[8*(k % 4) +: 8], in_b);
         chk("hd_out", HOUT[8*(k % 4) +: 8], out_b);
      end
      for (i = 18; i >= 0; i = i - 1) begin
         ent = CORNER[20*i +: 20];
         step(ent[15:0], ent[16]);
      end
      for (i = 0; i < 40; i = i + 1) begin
         r = $urandom;
         ord = r[15:0];
         if (r[16])
            ord[15:8] = 8'h00;
         if (r[17])
            ord[7:0] = r[18] ? 8'h08 : 8'hf4 + {5'h0, r[21:19]};
         step(ord, r[22]);
      end
      finish_test;
   end
endmodule // rcc_unit_bench
